// *** hdl/ccr_regs.sv ***
// Channel offset, gain and settings registers behind an AHB-Lite slave.
`timescale 1ns/1ns
`include "ccr_defines.svh"
module ccr_regs
    import ccr_pkg::*;
#(
    parameter int NREG = 7
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [23:0] chan0_offset_o,
    output logic [23:0] chan0_gain_o,
    output logic [23:0] chan1_offset_o,
    output logic signed [9:0] chan1_delay_count_o,
    output logic chan1_dc_filter_off_o,
    input wire logic global_dc_filter_setting_i,
    output logic chan1_dc_filter_active_o,
    output logic [1:0] chan1_input_select_o
);
    // ****************************************************************
    // Register index table.
    // ****************************************************************
    localparam logic [4:0] IDX [NREG] = '{`CCR_IDX_C0_OFS_HI,
        `CCR_IDX_C0_OFS_LO, `CCR_IDX_C0_GAIN_HI, `CCR_IDX_C0_GAIN_LO,
        `CCR_IDX_C1_SET, `CCR_IDX_C1_OFS_HI, `CCR_IDX_C1_OFS_LO};
    localparam logic [15:0] RST [NREG] = '{`CCR_RST_ZERO, `CCR_RST_ZERO,
        `CCR_RST_GAIN_HI, `CCR_RST_ZERO, `CCR_RST_ZERO, `CCR_RST_ZERO,
        `CCR_RST_ZERO};
    localparam logic [15:0] MSK [NREG] = '{16'hffff, `CCR_MASK_LO,
        16'hffff, `CCR_MASK_LO, `CCR_MASK_SET, 16'hffff, `CCR_MASK_LO};

    // ****************************************************************
    // Address phase capture.
    // ****************************************************************
    ccr_bus_state_type state_q;
    logic wr_q;
    logic [4:0] idx_q;
    logic [NREG-1:0] hit;
    logic [NREG-1:0] we;
    logic [15:0] q [NREG];
    logic [15:0] rd_mux;
    logic take;
    logic map_a;
    logic map_q;

    assign take = hsel_i && hready_i && htrans_i[1];
    assign map_a = (haddr_i[31:7] == 25'h000_0000);
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_q <= CCR_BUS_IDLE;
            wr_q <= 1'b0;
            idx_q <= 5'h0_0;
            map_q <= 1'b0;
        end else if (hready_i) begin
            state_q <= take ? CCR_BUS_DATA : CCR_BUS_IDLE;
            wr_q <= take && hwrite_i && map_a;
            idx_q <= haddr_i[6:2];
            map_q <= map_a;
        end
    end

    // ****************************************************************
    // Register words; reserved bits are masked to zero.
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_reg
            assign hit[g] = map_q && (idx_q == IDX[g]);
            assign we[g] = wr_q && hit[g];
            ccr_reg_word #(
                .RESET_VAL(RST[g]),
                .WR_MASK(MSK[g])
            ) u_word (
                .clk_i(clk_i),
                .resetn_i(resetn_i),
                .we_i(we[g]),
                .wdata_i(hwdata_i[15:0]),
                .q_o(q[g])
            );
        end
    endgenerate

    always_comb begin
        rd_mux = 16'h0000;
        for (int i = 0; i < NREG; i++) begin
            if (hit[i]) begin
                rd_mux = q[i];
            end
        end
    end

    // Read data is registered on the address phase for the data phase.
    // A write to that register landing on the same edge is passed through with its write mask applied.
    logic [NREG-1:0] hit_a;
    generate
        for (g = 0; g < NREG; g++) begin : g_hita
            assign hit_a[g] = map_a && (haddr_i[6:2] == IDX[g]);
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (take && !hwrite_i) begin
            hrdata_o <= 32'h0000_0000;
            for (int i = 0; i < NREG; i++) begin
                if (hit_a[i] && we[i]) begin
                    hrdata_o <= {16'h0000, (hwdata_i[15:0] & MSK[i])};
                end else if (hit_a[i]) begin
                    hrdata_o <= {16'h0000, q[i]};
                end
            end
        end
    end

    // ****************************************************************
    // Assembled correction words and settings fields.
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            chan0_offset_o <= 24'h00_0000;
            chan0_gain_o <= {`CCR_RST_GAIN_HI, 8'h00};
            chan1_offset_o <= 24'h00_0000;
        end else begin
            chan0_offset_o <= {q[0], q[1][15:8]};
            chan0_gain_o <= {q[2], q[3][15:8]};
            chan1_offset_o <= {q[5], q[6][15:8]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            chan1_delay_count_o <= 10'sh000;
            chan1_dc_filter_off_o <= 1'b0;
            chan1_dc_filter_active_o <= 1'b0;
            chan1_input_select_o <= CCR_SEL_NORMAL;
        end else begin
            chan1_delay_count_o <= q[4][15:6];
            chan1_dc_filter_off_o <= q[4][2];
            chan1_dc_filter_active_o <= !q[4][2] &&
                global_dc_filter_setting_i;
            chan1_input_select_o <= q[4][1:0];
        end
    end

    // ****************************************************************
    // Reset value assertions.
    // ****************************************************************
    AST_GAIN_RESET: assert property (@(posedge clk_i)
        $rose(resetn_i) |-> q[2] == 16'h8000 && q[0] == 16'h0000)
        else $error("gain upper reset value wrong");
    AST_RST_OFS: assert property (@(posedge clk_i)
        $rose(resetn_i) |-> q[0] == `CCR_RST_ZERO && q[1] == `CCR_RST_ZERO
        && q[5] == `CCR_RST_ZERO && q[6] == `CCR_RST_ZERO)
        else $error("offset registers not cleared by reset");
    AST_RST_GLO: assert property (@(posedge clk_i)
        $rose(resetn_i) |-> q[3] == `CCR_RST_ZERO)
        else $error("lower gain register not cleared by reset");
    AST_RST_SET: assert property (@(posedge clk_i)
        $rose(resetn_i) |-> q[4] == `CCR_RST_ZERO)
        else $error("settings register not cleared by reset");
    AST_RST_WORDS: assert property (@(posedge clk_i)
        $rose(resetn_i) |-> chan0_gain_o == 24'h80_0000
        && chan0_offset_o == 24'h00_0000 && chan1_offset_o == 24'h00_0000)
        else $error("correction words wrong after reset");
    AST_RST_FIELDS: assert property (@(posedge clk_i)
        $rose(resetn_i) |-> chan1_delay_count_o == 10'sh000
        && !chan1_dc_filter_off_o && chan1_input_select_o == CCR_SEL_NORMAL)
        else $error("settings fields wrong after reset");
    generate
        for (g = 0; g < NREG; g++) begin : g_rst_chk
            AST_WORD_RESET: assert property (@(posedge clk_i)
                $rose(resetn_i) |-> q[g] == RST[g])
                else $error("register word wrong after reset");
        end
    endgenerate

    // ****************************************************************
    // Reserved bit and read path assertions.
    // ****************************************************************
    AST_LO_RESERVED: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        q[1][7:0] == 8'h00 && q[3][7:0] == 8'h00 && q[6][7:0] == 8'h00)
        else $error("reserved low byte not zero");
    AST_SET_RESERVED: assert property (@(posedge clk_i)
        disable iff (!resetn_i) q[4][5:3] == 3'b000)
        else $error("reserved settings bits not zero");
    AST_RD_DATA: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        (state_q == CCR_BUS_DATA && !wr_q)
        |-> hrdata_o == {16'h0000, rd_mux})
        else $error("read data differs from the addressed register");
    AST_RD_HOLD: assert property (@(posedge clk_i)
        (resetn_i && !(take && !hwrite_i)) |=> $stable(hrdata_o))
        else $error("read data changed outside a read");

    // ****************************************************************
    // Register write assertions.
    // ****************************************************************
    AST_WRITE_SET: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        we[4] |=> q[4] == ($past(hwdata_i[15:0]) & `CCR_MASK_SET))
        else $error("settings write lost");
    AST_OFS_ADDR: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        (wr_q && idx_q == `CCR_IDX_C0_OFS_HI)
        |=> q[0] == $past(hwdata_i[15:0]))
        else $error("offset at index Ah not written");
    AST_LO_WRITE: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        we[1] |=> q[1][15:8] == $past(hwdata_i[15:8]))
        else $error("lower offset write lost");
    AST_GLO_WRITE: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        we[3] |=> q[3][15:8] == $past(hwdata_i[15:8]))
        else $error("lower gain write lost");
    AST_HI_WRITE: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        we[0] |=> q[0] == $past(hwdata_i[15:0]))
        else $error("upper offset write lost");
    AST_GHI_WRITE: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        we[2] |=> q[2] == $past(hwdata_i[15:0]))
        else $error("upper gain write lost");
    AST_OFS1_HI: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        we[5] |=> q[5] == $past(hwdata_i[15:0]))
        else $error("chan1 upper offset write lost");
    AST_OFS1_LO: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        we[6] |=> q[6][15:8] == $past(hwdata_i[15:8]))
        else $error("chan1 lower offset write lost");
    AST_UNMAPPED: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        (take && hwrite_i && !map_a) |=> we == {NREG{1'b0}})
        else $error("write outside the bank reached a register");
    AST_WR_PHASE: assert property (@(posedge clk_i)
        (resetn_i && take && hwrite_i && map_a)
        |=> wr_q && state_q == CCR_BUS_DATA)
        else $error("write data phase not entered");
    generate
        for (g = 0; g < NREG; g++) begin : g_wr_chk
            AST_WORD_WRITE: assert property (@(posedge clk_i)
                (resetn_i && we[g])
                |=> q[g] == ($past(hwdata_i[15:0]) & MSK[g]))
                else $error("register word write lost");
            AST_WORD_HOLD: assert property (@(posedge clk_i)
                (resetn_i && !we[g]) |=> $stable(q[g]))
                else $error("register word changed without a write");
        end
    endgenerate

    // ****************************************************************
    // Output field assertions.
    // ****************************************************************
    AST_OFS0_WORD: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        resetn_i |=> chan0_offset_o == {$past(q[0]), $past(q[1][15:8])})
        else $error("offset word mismatch");
    AST_GAIN_WORD: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        resetn_i |=> chan0_gain_o == {$past(q[2]), $past(q[3][15:8])})
        else $error("gain word mismatch");
    AST_OFS1_WORD: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        resetn_i |=> chan1_offset_o == {$past(q[5]), $past(q[6][15:8])})
        else $error("chan1 offset mismatch");
    AST_DELAY: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        we[4] |=> ##1 chan1_delay_count_o == $past(hwdata_i[15:6], 2))
        else $error("delay field wrong");
    AST_DCOFF: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        chan1_dc_filter_off_o |-> !chan1_dc_filter_active_o)
        else $error("dc filter not disabled");
    AST_SEL: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        we[4] |=> ##1 chan1_input_select_o == $past(hwdata_i[1:0], 2))
        else $error("input select wrong");
    AST_DCACT: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        resetn_i |=> chan1_dc_filter_active_o
        == (!$past(q[4][2]) && $past(global_dc_filter_setting_i)))
        else $error("dc filter global control wrong");
    AST_DCOFF_FIELD: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        we[4] |=> ##1 chan1_dc_filter_off_o == $past(hwdata_i[2], 2))
        else $error("dc filter disable bit wrong");
endmodule : ccr_regs

// *** hdl/ccr_defines.svh ***
// Offsets, field positions and reset values of the channel settings bank.
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH
// ****************************************************************
// Register indices; byte address is four times the index.
// ****************************************************************
`define CCR_IDX_C0_OFS_HI 5'h0a
`define CCR_IDX_C0_OFS_LO 5'h0b
`define CCR_IDX_C0_GAIN_HI 5'h0c
`define CCR_IDX_C0_GAIN_LO 5'h0d
`define CCR_IDX_C1_SET 5'h0e
`define CCR_IDX_C1_OFS_HI 5'h0f
`define CCR_IDX_C1_OFS_LO 5'h10
// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define CCR_LO_FIELD_MSB 15
`define CCR_LO_FIELD_LSB 8
`define CCR_DELAY_MSB 15
`define CCR_DELAY_LSB 6
`define CCR_DCOFF_BIT 2
`define CCR_SEL_MSB 1
`define CCR_SEL_LSB 0
`define CCR_RST_ZERO 16'h0000
`define CCR_RST_GAIN_HI 16'h8000
`define CCR_MASK_LO 16'hff00
`define CCR_MASK_SET 16'hffc7
`endif

// *** hdl/ccr_pkg.sv ***
// Types shared by the channel settings bank.
package ccr_pkg;
    typedef enum logic [1:0] {
        CCR_SEL_NORMAL = 2'b00,
        CCR_SEL_SHORT = 2'b01,
        CCR_SEL_TEST_POS = 2'b10,
        CCR_SEL_TEST_NEG = 2'b11
    } ccr_input_sel_type;
    typedef enum logic [0:0] {
        CCR_BUS_IDLE = 1'b0,
        CCR_BUS_DATA = 1'b1
    } ccr_bus_state_type;
endpackage : ccr_pkg

// *** hdl/ccr_reg_word.sv ***
// One 16-bit settings register with write mask and reset value.
`timescale 1ns/1ns
module ccr_reg_word #(
    parameter logic [15:0] RESET_VAL = 16'h0000,
    parameter logic [15:0] WR_MASK = 16'hffff
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic we_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] q_o
);
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            q_o <= RESET_VAL;
        end else if (we_i) begin
            q_o <= wdata_i & WR_MASK;
        end
    end
endmodule : ccr_reg_word

// *** verification/tb_channel_cal_config_regs.sv ***
// Self-checking testbench of the channel settings register bank.
`timescale 1ns/1ns
`include "ccr_defines.svh"
module tb_channel_cal_config_regs
    import ccr_pkg::*;
;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    logic gdc = 1'b0;
    logic [24:0] hi = 25'h000_0000;
    logic [31:0] hrdata;
    logic hrdy;
    logic hresp;
    logic [23:0] c0o;
    logic [23:0] c0g;
    logic [23:0] c1o;
    logic signed [9:0] dly;
    logic dcoff;
    logic dcact;
    logic [1:0] sel;
    logic [15:0] ex [7];
    int err_total = 0;
    int total_checks = 0;
    always #5 clk_i = ~clk_i;
    ccr_regs dut (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .chan0_offset_o(c0o), .chan0_gain_o(c0g), .chan1_offset_o(c1o),
        .chan1_delay_count_o(dly), .chan1_dc_filter_off_o(dcoff),
        .global_dc_filter_setting_i(gdc), .chan1_dc_filter_active_o(dcact),
        .chan1_input_select_o(sel));
    // ****************************************************************
    // Expected values and checks.
    // ****************************************************************
    function automatic logic [15:0] msk(input int i);
        if (i == 4) return `CCR_MASK_SET;
        return (i == 1 || i == 3 || i == 6) ? `CCR_MASK_LO : 16'hffff;
    endfunction : msk
    function automatic logic [15:0] rst(input int i);
        return (i == 2) ? `CCR_RST_GAIN_HI : `CCR_RST_ZERO;
    endfunction : rst
    task automatic results();
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    task automatic check_rd(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp || hresp !== 1'b0) begin
            err_total++;
            $display("ERROR %0t read %h expected %h", $time, got, exp);
        end
    endtask : check_rd
    task automatic check_out(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t output %h expected %h", $time, got, exp);
        end
    endtask : check_out
    // ****************************************************************
    // Bus cycles.
    // ****************************************************************
    task automatic wait_rdy();
        int n = 0;
        @(posedge clk_i);
        while (hrdy !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_total++;
                $display("ERROR %0t bus wait timed out", $time);
                results();
            end
            @(posedge clk_i);
        end
    endtask : wait_rdy
    task automatic ahb(input logic wr, input logic [4:0] idx,
        input logic [15:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {hi, idx, 2'b00};
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {16'h0000, wd};
        wait_rdy();
        rd = hrdata;
    endtask : ahb
    task automatic check_fields();
        repeat (2) @(posedge clk_i);
        #1;
        check_out({8'h00, c0o}, {8'h00, ex[0], ex[1][15:8]});
        check_out({8'h00, c0g}, {8'h00, ex[2], ex[3][15:8]});
        check_out({8'h00, c1o}, {8'h00, ex[5], ex[6][15:8]});
        check_out({22'h00_0000, dly}, {22'h00_0000, ex[4][15:6]});
        check_out({31'h0, dcoff}, {31'h0, ex[4][2]});
        check_out({31'h0, dcact}, {31'h0, ~ex[4][2] & gdc});
        check_out({30'h0, sel}, {30'h0, ex[4][1:0]});
    endtask : check_fields
    task automatic chk_reset();
        logic [31:0] rd;
        for (int i = 0; i < 7; i++) begin
            ahb(1'b0, 5'h0a + i[4:0], 16'h0000, rd);
            check_rd(rd, {16'h0000, rst(i)});
            ex[i] = rst(i);
        end
        check_fields();
    endtask : chk_reset
    // ****************************************************************
    // Test sequence.
    // ****************************************************************
    initial begin
        logic [15:0] wd;
        logic [31:0] rd;
        logic [9:0] d;
        void'($urandom(32'hab75));
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        chk_reset();
        $display("Test reset values done");
        ahb(1'b1, 5'h09, 16'hffff, rd);
        ahb(1'b0, 5'h09, 16'h0000, rd);
        check_rd(rd, 32'h0000_0000);
        hi = 25'h000_0001;
        ahb(1'b1, `CCR_IDX_C0_OFS_HI, 16'hffff, rd);
        ahb(1'b0, `CCR_IDX_C0_OFS_HI, 16'h0000, rd);
        check_rd(rd, 32'h0000_0000);
        hi = 25'h000_0000;
        ahb(1'b0, `CCR_IDX_C0_OFS_HI, 16'h0000, rd);
        check_rd(rd, 32'h0000_0000);
        $display("Test unmapped place done");
        for (int k = 0; k < 20; k++) begin
            gdc <= 1'($urandom);
            for (int i = 0; i < 7; i++) begin
                wd = (k == 0) ? 16'hffff : 16'($urandom);
                ahb(1'b1, 5'h0a + i[4:0], wd, rd);
                ex[i] = wd & msk(i);
            end
            for (int i = 0; i < 7; i++) begin
                ahb(1'b0, 5'h0a + i[4:0], 16'h0000, rd);
                check_rd(rd, {16'h0000, ex[i]});
            end
            check_fields();
        end
        $display("Test random words done");
        for (int k = 0; k < 8; k++) begin
            d = (k == 0) ? 10'h200 : (k == 1) ? 10'h1ff : 10'($urandom);
            gdc <= ~gdc;
            wd = {d, 3'b111, k[2:0]};
            ahb(1'b1, `CCR_IDX_C1_SET, wd, rd);
            ex[4] = wd & msk(4);
            ahb(1'b0, `CCR_IDX_C1_SET, 16'h0000, rd);
            check_rd(rd, {16'h0000, d, 3'b000, k[2:0]});
            check_fields();
        end
        $display("Test settings codes done");
        @(posedge clk_i);
        resetn_i <= 1'b0;
        @(posedge clk_i);
        resetn_i <= 1'b1;
        chk_reset();
        $display("Test second reset done");
        results();
    end
    initial begin
        #200_000;
        err_total++;
        $display("ERROR %0t watchdog expired", $time);
        results();
    end
endmodule : tb_channel_cal_config_regs
